// ### hdl/pbc_pkg.sv
// constants and register map for the loop bandwidth and programming control block
// ============================================================================
// Summary of operation
// RULE_01: automatic bandwidth bit is read/write, one selects automatic, reset clears it.
// RULE_02: lock indicator reads live lock in automatic mode, zero in manual, reset clears.
// RULE_03: in automatic mode tracking bit is read-only and shows loop state.
// RULE_04: in manual mode tracking bit is writable and forces tracking or acquisition.
// RULE_05: manual tracking value is held while automatic, restored when manual resumes.
// RULE_06: reset clears tracking bit so the loop starts in acquisition.
// RULE_07: software clears tracking bit before turning loop on in manual mode.
// RULE_08: writing one to crystal-loss bit checks reference over N times 4 cycles.
// RULE_09: crystal-loss check works only with vco clock selected, else reads zero.
// RULE_10: software writes zeros to the four low test bits of bandwidth control.
// RULE_11: multiplier field sets N from 1 to 15, zero behaves as one.
// RULE_12: reset sets multiplier field to six.
// RULE_13: multiplier writes are ignored while loop is on.
// RULE_14: vco range writes are ignored while loop is on.
// RULE_15: zero vco range disables loop, clears base select and blocks setting it.
// RULE_16: reset sets vco range field to six.
// RULE_17: in automatic mode lock changes set event flag; request only when enabled.
// RULE_18: manual mode blocks loop interrupts and event flag reads zero.
// RULE_19: vco clock may be selected while unlocked; software should check lock first.
// RULE_20: oscillator enable low disables block and holds clock and interrupt outputs low.
// RULE_21: stop with vco selected clears base select, which stays clear afterwards.
// RULE_22: in break with clear enable zero, control access keeps the event flag.
// RULE_23: any read of control register clears the event flag outside break protection.
// RULE_24: base select cannot be set while loop is off; two writes needed.
// RULE_25: interrupt output is a level while event flag and enable are both set.
package pbc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] PBC_LOOP_CONTROL_REG_ADDR  = 8'h1C;
  localparam logic [7:0] PBC_BANDWIDTH_CONTROL_ADDR = 8'h1D;
  localparam logic [7:0] PBC_LOOP_PROGRAMMING_ADDR  = 8'h1E;

  // ==========================================================================
  // loop control register fields
  localparam int PBC_CTL_IRQ_EN_BIT = 7;
  localparam int PBC_CTL_FLAG_BIT   = 6;
  localparam int PBC_CTL_ON_BIT     = 5;
  localparam int PBC_CTL_SEL_BIT    = 4;
  localparam logic [3:0] PBC_CTL_LOW_READ = 4'h_F;

  // ==========================================================================
  // bandwidth control register fields
  localparam int PBC_BWC_AUTO_BIT  = 7;
  localparam int PBC_BWC_LOCK_BIT  = 6;
  localparam int PBC_BWC_TRACK_BIT = 5;
  localparam int PBC_BWC_LOSS_BIT  = 4;
  localparam logic [3:0] PBC_BWC_LOW_READ = 4'h_0;

  // ==========================================================================
  // programming register fields and reset values
  localparam int PBC_PRG_MUL_LSB = 4;
  localparam int PBC_PRG_RANGE_LSB = 0;
  localparam logic [3:0] PBC_MUL_RESET   = 4'h_6;
  localparam logic [3:0] PBC_RANGE_RESET = 4'h_6;
  localparam logic       PBC_ON_RESET  = 1'b1;

  // ==========================================================================
  // crystal check: wait of N times this many cycles
  localparam int PBC_LOSS_CYCLES_PER_N = 4;
  localparam logic [7:0] PBC_RD_UNMAPPED = 8'h_00;

  // multiplier field to effective N, zero acts as one
  function automatic logic [3:0] pbcEffN(input logic [3:0] field);
    pbcEffN = (field == 4'h_0) ? 4'h_1 : field;
  endfunction

endpackage

// ### hdl/pbc_xtal_check.sv
// crystal reference activity check timed by the loop multiplier
`timescale 1ns/100ps
module pbc_xtal_check
  import pbc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       start,
  input  wire logic [3:0] factorN,
  input  wire logic       crystalIn,
  output logic            lossQ
);

  typedef struct packed {
    logic       busy;
    logic       seen;
    logic       prevXtal;
    logic [5:0] count;
    logic       loss;
  } pbc_loss_state_t;

  pbc_loss_state_t st_q;
  pbc_loss_state_t st_d;

  always_comb begin
    st_d          = st_q;
    st_d.prevXtal = crystalIn;
    if (!enable) begin
      // check only meaningful with vco clock driving base clock [RULE_09]
      st_d.busy = 1'b0;
      st_d.loss = 1'b0;
    end else if (start) begin
      // window of N times four cycles [RULE_08]
      st_d.busy  = 1'b1;
      st_d.seen  = 1'b0;
      st_d.count = 6'(pbcEffN(factorN) * PBC_LOSS_CYCLES_PER_N);
    end else if (st_q.busy) begin
      if (crystalIn != st_q.prevXtal) begin
        st_d.seen = 1'b1;
      end
      if (st_q.count <= 6'h_01) begin
        st_d.busy = 1'b0;
        st_d.loss = !(st_q.seen || (crystalIn != st_q.prevXtal)); // [RULE_08]
      end else begin
        st_d.count = st_q.count - 6'h_01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lossQ = st_q.loss;

endmodule

// ### hdl/pbc_loop_ctrl.sv
// register file and control logic for loop bandwidth, programming and base clock select
`timescale 1ns/100ps
module pbc_loop_ctrl
  import pbc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wrData,
  input  wire logic              wrEn,
  input  wire logic              rdEn,
  output logic      [7:0]        rdData,
  input  wire logic              loopLockedIn,
  input  wire logic              loopTrackingIn,
  input  wire logic              crystalClockIn,
  input  wire logic              vcoClockIn,
  input  wire logic              oscillatorEnableIn,
  input  wire logic              breakStateIn,
  input  wire logic              breakClearEnableIn,
  output logic                   crystalClockOut,
  output logic                   baseClockOut,
  output logic                   loopInterruptOut,
  output logic                   loopPowerOnOut,
  output logic                   trackingModeOut,
  output logic                   autoModeOut,
  output logic      [3:0]        loopFactorNOut,
  output logic      [3:0]        vcoRangeOut
);

  // ==========================================================================
  // elaboration check
  if (ADDR_W < 8) begin : g_addr_check
    $error("pbc_loop_ctrl: ADDR_W must be at least 8");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic       irqEn;
    logic       flag;
    logic       loopOn;
    logic       baseSel;
    logic       autoMode;
    logic       lock;
    logic       manualTrack;
    logic [3:0] mul;
    logic [3:0] vcoRange;
    logic [7:0] rdData;
    logic       prevXtal;
    logic       prevVco;
    logic       baseClk;
    logic       xclkOut;
    logic       irqOut;
    logic       powerOut;
    logic       trackOut;
    logic [3:0] nOut;
  } pbc_ctrl_state_t;

  pbc_ctrl_state_t st_q;
  pbc_ctrl_state_t st_d;

  logic xtalLoss;
  logic lossStart;
  logic selCtrl;
  logic selBwc;
  logic selPrg;
  logic flagProtected;

  // ==========================================================================
  // address decode
  always_comb begin
    selCtrl = (addr == ADDR_W'(PBC_LOOP_CONTROL_REG_ADDR));
    selBwc  = (addr == ADDR_W'(PBC_BANDWIDTH_CONTROL_ADDR));
    selPrg  = (addr == ADDR_W'(PBC_LOOP_PROGRAMMING_ADDR));
  end

  // break state with clearing not permitted shields the event flag
  assign flagProtected = breakStateIn && !breakClearEnableIn;    // [RULE_22]
  assign lossStart     = wrEn && selBwc && wrData[PBC_BWC_LOSS_BIT];

  // ==========================================================================
  // crystal loss checker
  pbc_xtal_check u_xtal_check (
    .clk      (clk),
    .rst      (rst),
    .enable   (st_q.baseSel),
    .start    (lossStart),
    .factorN  (st_q.mul),
    .crystalIn(crystalClockIn),
    .lossQ    (xtalLoss)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic rangeZero;
    logic selClk;
    logic prevSel;
    rangeZero = 1'b0;
    selClk  = 1'b0;
    prevSel = 1'b0;
    st_d    = st_q;

    // ------------------------------------------------------------------------
    // read path, data stands in the cycle after the strobe
    st_d.rdData = PBC_RD_UNMAPPED;
    if (rdEn) begin
      if (selCtrl) begin
        // enable and flag read as zero in manual mode [RULE_18]
        st_d.rdData = {st_q.irqEn & st_q.autoMode, st_q.flag & st_q.autoMode,
                       st_q.loopOn, st_q.baseSel, PBC_CTL_LOW_READ};
      end else if (selBwc) begin
        st_d.rdData = {st_q.autoMode,
                       st_q.lock & st_q.autoMode,                         // [RULE_02]
                       st_q.autoMode ? loopTrackingIn : st_q.manualTrack, // [RULE_03]
                       xtalLoss & st_q.baseSel,                           // [RULE_09]
                       PBC_BWC_LOW_READ};
      end else if (selPrg) begin
        st_d.rdData = {st_q.mul, st_q.vcoRange};
      end
    end

    // ------------------------------------------------------------------------
    // lock tracking and event flag; the clear by read yields to a new event
    st_d.lock = loopLockedIn;
    if (rdEn && selCtrl && !flagProtected) begin
      st_d.flag = 1'b0;                                           // [RULE_23]
    end
    if (!st_q.autoMode) begin
      st_d.flag = 1'b0;                                           // [RULE_18]
    end else if (loopLockedIn != st_q.lock) begin
      st_d.flag = 1'b1;                                           // [RULE_17]
    end

    // ------------------------------------------------------------------------
    // register writes
    if (wrEn && selCtrl) begin
      if (st_q.autoMode) begin
        st_d.irqEn = wrData[PBC_CTL_IRQ_EN_BIT];
      end
      // loop cannot be switched off while it drives the base clock
      st_d.loopOn = st_q.baseSel ? 1'b1 : wrData[PBC_CTL_ON_BIT];
      // selection needs the loop already on, so turning on and selecting take two writes;
      // lock is not required here, software is expected to check it first
      if (!wrData[PBC_CTL_SEL_BIT]) begin
        st_d.baseSel = 1'b0;
      end else if (st_q.loopOn && st_q.vcoRange != 4'h_0) begin
        st_d.baseSel = 1'b1;                                      // [RULE_24] [RULE_19]
      end
    end

    if (wrEn && selBwc) begin
      // low test bits are written as zero by software and have no function here [RULE_10]
      st_d.autoMode = wrData[PBC_BWC_AUTO_BIT];                   // [RULE_01]
      if (!st_q.autoMode) begin
        // held while automatic, so it returns unchanged on the way back [RULE_04] [RULE_05]
        st_d.manualTrack = wrData[PBC_BWC_TRACK_BIT];
      end
    end

    if (wrEn && selPrg && !st_q.loopOn) begin
      st_d.mul = wrData[PBC_PRG_MUL_LSB +: 4];                    // [RULE_13]
      st_d.vcoRange = wrData[PBC_PRG_RANGE_LSB +: 4];             // [RULE_14]
    end

    // ------------------------------------------------------------------------
    // zero range disables the loop and forces the crystal clock
    rangeZero = (st_d.vcoRange == 4'h_0);
    if (rangeZero) begin
      st_d.baseSel = 1'b0;                                        // [RULE_15]
    end

    // ------------------------------------------------------------------------
    // stop: oscillator enable low drops back to the crystal and silences the clock, interrupt and loop power outputs
    if (!oscillatorEnableIn) begin
      st_d.baseSel = 1'b0;                                        // [RULE_21]
    end

    // ------------------------------------------------------------------------
    // base clock is the selected clock halved; edges are taken from sampled inputs,
    // so the output is only as exact as the sampling rate allows
    st_d.prevXtal = crystalClockIn;
    st_d.prevVco  = vcoClockIn;
    selClk        = st_q.baseSel ? vcoClockIn : crystalClockIn;
    prevSel       = st_q.baseSel ? st_q.prevVco : st_q.prevXtal;
    if (!oscillatorEnableIn) begin
      st_d.baseClk = 1'b0;                                        // [RULE_20]
      st_d.xclkOut = 1'b0;
    end else begin
      if (selClk && !prevSel) begin
        st_d.baseClk = !st_q.baseClk;
      end
      st_d.xclkOut = crystalClockIn;
    end

    // ------------------------------------------------------------------------
    // interrupt level and loop control outputs
    st_d.irqOut = oscillatorEnableIn && st_d.autoMode
                  && st_d.flag && st_d.irqEn;                     // [RULE_25] [RULE_17] [RULE_20]
    st_d.powerOut = st_d.loopOn && !rangeZero && oscillatorEnableIn;
    // manual value drives the loop; automatic leaves it to the analog detector
    st_d.trackOut = st_d.autoMode ? loopTrackingIn : st_d.manualTrack;
    st_d.nOut     = pbcEffN(st_d.mul);                            // [RULE_11]
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q             <= '0;
      st_q.autoMode    <= 1'b0;                                   // [RULE_01]
      st_q.lock        <= 1'b0;                                   // [RULE_02]
      st_q.manualTrack <= 1'b0;                                   // [RULE_06]
      st_q.loopOn      <= PBC_ON_RESET;
      st_q.mul         <= PBC_MUL_RESET;                          // [RULE_12]
      st_q.vcoRange    <= PBC_RANGE_RESET;                        // [RULE_16]
      st_q.nOut        <= PBC_MUL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  assign rdData           = st_q.rdData;
  assign crystalClockOut  = st_q.xclkOut;
  assign baseClockOut     = st_q.baseClk;
  assign loopInterruptOut = st_q.irqOut;
  assign loopPowerOnOut   = st_q.powerOut;
  assign trackingModeOut  = st_q.trackOut;
  assign autoModeOut      = st_q.autoMode;
  assign loopFactorNOut   = st_q.nOut;
  assign vcoRangeOut      = st_q.vcoRange;

endmodule

// ### verif/pbc_loop_ctrl_props.sv
// port-level assertions for the loop control block
`timescale 1ns/100ps
module pbc_loop_ctrl_props
  import pbc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              wrEn,
  input wire logic              rdEn,
  input wire logic [7:0]        rdData,
  input wire logic              loopTrackingIn,
  input wire logic              oscillatorEnableIn,
  input wire logic              crystalClockOut,
  input wire logic              baseClockOut,
  input wire logic              loopInterruptOut,
  input wire logic              loopPowerOnOut,
  input wire logic              trackingModeOut,
  input wire logic              autoModeOut,
  input wire logic [3:0]        loopFactorNOut,
  input wire logic [3:0]        vcoRangeOut
);
  // ==========================================================================
  // sequences and properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_bw_read;
    rdEn && addr == PBC_BANDWIDTH_CONTROL_ADDR;
  endsequence
  // past term keeps a just-switched-on loop from looking locked
  sequence s_prg_locked_wr;
    wrEn && addr == PBC_LOOP_PROGRAMMING_ADDR && loopPowerOnOut && $past(loopPowerOnOut);
  endsequence
  property p_stop_low;
    !oscillatorEnableIn |=> !crystalClockOut && !baseClockOut && !loopInterruptOut;
  endproperty
  property p_prog_locked;
    s_prg_locked_wr |=> ($stable(loopFactorNOut) && $stable(vcoRangeOut)) [*2];
  endproperty
  property p_n_nonzero;
    loopFactorNOut != 4'h0;
  endproperty
  property p_manual_noint;
    !autoModeOut |-> !loopInterruptOut;
  endproperty
  property p_auto_track;
    autoModeOut && $past(autoModeOut) |-> trackingModeOut == $past(loopTrackingIn);
  endproperty
  property p_int_level;
    loopInterruptOut |-> autoModeOut && $past(oscillatorEnableIn);
  endproperty
  property p_lock_manual;
    s_bw_read ##0 !autoModeOut |=> rdData[6] == 1'b0 && rdData[3:0] == 4'h0;
  endproperty
  property p_vrs_zero;
    vcoRangeOut == 4'h0 && $past(vcoRangeOut) == 4'h0 |-> !loopPowerOnOut;
  endproperty
  // ==========================================================================
  // assertions
  a_stop_low: assert property (p_stop_low) else $error("outputs live in stop");
  a_prog_locked: assert property (p_prog_locked) else $error("program changed while on");
  a_n_nonzero: assert property (p_n_nonzero) else $error("multiplier zero");
  a_manual_noint: assert property (p_manual_noint) else $error("interrupt in manual");
  a_auto_track: assert property (p_auto_track) else $error("tracking not followed");
  a_int_level: assert property (p_int_level) else $error("interrupt without cause");
  a_lock_manual: assert property (p_lock_manual) else $error("lock bit in manual");
  a_vrs_zero: assert property (p_vrs_zero) else $error("loop on with zero range");
endmodule

// ### verif/pbc_sys_model.sv
// clock sources and stop control on the far side of the loop control block
`timescale 1ns/100ps
module pbc_sys_model (
  input  wire logic clk,
  input  wire logic xtalRun,
  input  wire logic stopReq,
  output logic      crystalClockIn,
  output logic      vcoClockIn,
  output logic      oscillatorEnableIn
);
  logic [1:0] divQ;
  initial begin
    divQ = 2'h0;
    crystalClockIn = 1'b0;
    vcoClockIn = 1'b0;
    oscillatorEnableIn = 1'b1;
  end
  // a dead crystal freezes at whatever level it last had
  always @(posedge clk) begin
    divQ <= divQ + 2'h1;
    vcoClockIn <= ~vcoClockIn;
    if (xtalRun && divQ == 2'h3) begin
      crystalClockIn <= ~crystalClockIn;
    end
    oscillatorEnableIn <= ~stopReq;
  end
endmodule

// ### verif/pbc_loop_ctrl_tb.sv
// self-checking bench for the loop control block
`timescale 1ns/100ps
module pbc_loop_ctrl_tb
  import pbc_pkg::*;
();
  localparam logic [7:0] CTL = PBC_LOOP_CONTROL_REG_ADDR;
  localparam logic [7:0] BWC = PBC_BANDWIDTH_CONTROL_ADDR;
  localparam logic [7:0] PRG = PBC_LOOP_PROGRAMMING_ADDR;
  localparam int         ADDR_W = 8;
  logic       clk, crystalClockIn, vcoClockIn, oscillatorEnableIn, crystalClockOut, baseClockOut;
  logic       loopInterruptOut, loopPowerOnOut, trackingModeOut, autoModeOut;
  logic       rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0, loopLockedIn = 1'b0, loopTrackingIn = 1'b0;
  logic       breakStateIn = 1'b0, breakClearEnableIn = 1'b0, xtalRun = 1'b1, stopReq = 1'b0;
  logic [7:0] addr = 8'h00, wrData = 8'h00, rdData, d;
  logic [3:0] loopFactorNOut, vcoRangeOut;
  int         err_count = 0, compares = 0;
  // reference register model
  bit         mOn = 1'b1, mSel = 1'b0, mAuto = 1'b0, mTrk = 1'b0, mIe = 1'b0, mFlag = 1'b0, mLoss = 1'b0;
  bit   [3:0] mMul = 4'h6, mRange = 4'h6;

  pbc_loop_ctrl #(.ADDR_W(ADDR_W)) pbc_loop_ctrl_i (
    .clk               (clk),
    .rst               (rst),
    .addr              (addr),
    .wrData            (wrData),
    .wrEn              (wrEn),
    .rdEn              (rdEn),
    .rdData            (rdData),
    .loopLockedIn      (loopLockedIn),
    .loopTrackingIn    (loopTrackingIn),
    .crystalClockIn    (crystalClockIn),
    .vcoClockIn        (vcoClockIn),
    .oscillatorEnableIn(oscillatorEnableIn),
    .breakStateIn      (breakStateIn),
    .breakClearEnableIn(breakClearEnableIn),
    .crystalClockOut   (crystalClockOut),
    .baseClockOut      (baseClockOut),
    .loopInterruptOut  (loopInterruptOut),
    .loopPowerOnOut    (loopPowerOnOut),
    .trackingModeOut   (trackingModeOut),
    .autoModeOut       (autoModeOut),
    .loopFactorNOut    (loopFactorNOut),
    .vcoRangeOut       (vcoRangeOut)
  );
  pbc_sys_model pbc_sys_model_i (
    .clk               (clk),
    .xtalRun           (xtalRun),
    .stopReq           (stopReq),
    .crystalClockIn    (crystalClockIn),
    .vcoClockIn        (vcoClockIn),
    .oscillatorEnableIn(oscillatorEnableIn)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================================
  // checking and bus tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] expOf(input logic [7:0] a);
    case (a)
      CTL: expOf = {mIe & mAuto, mFlag & mAuto, mOn, mSel, 4'hF};
      BWC: expOf = {mAuto, loopLockedIn & mAuto, mAuto ? loopTrackingIn : mTrk, mLoss & mSel, 4'h0};
      PRG: expOf = {mMul, mRange};
      default: expOf = 8'h00;
    endcase
  endfunction
  task automatic rc(input logic [7:0] a);
    logic [7:0] e;
    e = expOf(a);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk(rdData, e);
    if (a == CTL && !(breakStateIn && !breakClearEnableIn)) mFlag = 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bit o;
    o = mOn;
    if (a == CTL) begin
      mIe = mAuto ? v[7] : mIe;
      mOn = mSel | v[5];
      mSel = v[4] & o & (mRange != 4'h0);
    end
    if (a == BWC) begin
      mTrk = mAuto ? mTrk : v[5];
      mAuto = v[7];
      mFlag = mFlag & v[7];
    end
    if (a == PRG && !mOn) {mMul, mRange} = v;
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask
  // counts base clock changes over n cycles, sampled off the edge
  task automatic cnt_base(input int n, input int want);
    int   t;
    logic b;
    t = 0;
    #1 b = baseClockOut;
    repeat (n) begin
      @(posedge clk);
      #1 t += int'(baseClockOut != b);
      b = baseClockOut;
    end
    @(posedge clk);
    chk(8'(t), 8'(want));
  endtask
  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(32'h7ba7));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({loopFactorNOut, vcoRangeOut}, 8'h66);
    chk({6'h00, autoModeOut, trackingModeOut}, 8'h00);
    @(posedge clk);
    rc(BWC);
    rc(8'h1F);
    wr(PRG, 8'($urandom()));
    rc(PRG);
    wr(CTL, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom());
      if (i == 0) d[7:4] = 4'h0;
      wr(PRG, d);
      rc(PRG);
      chk({4'h0, loopFactorNOut}, (d[7:4] == 4'h0) ? 8'h01 : {4'h0, d[7:4]});
    end
    wr(PRG, 8'h20);
    wr(CTL, 8'h20);
    wr(CTL, 8'h30);
    rc(CTL);
    chk({7'h00, loopPowerOnOut}, 8'h00);
    wr(CTL, 8'h00);
    wr(PRG, 8'h26);
    wr(CTL, 8'h30);
    rc(CTL);
    wr(CTL, 8'h30);
    rc(CTL);
    chk({7'h00, loopPowerOnOut}, 8'h01);
    cnt_base(8, 4);
    // dead crystal first, then a live one, with the vco clock selected
    xtalRun <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      wr(BWC, 8'h10);
      repeat (4 * mMul + 2) @(posedge clk);
      mLoss = ~xtalRun;
      rc(BWC);
      xtalRun <= 1'b1;
    end
    stopReq <= 1'b1;
    repeat (4) @(posedge clk);
    chk({5'h00, crystalClockOut, baseClockOut, loopInterruptOut}, 8'h00);
    stopReq <= 1'b0;
    xtalRun <= 1'b0;
    mSel = 1'b0;
    repeat (3) @(posedge clk);
    rc(CTL);
    wr(BWC, 8'h10);
    repeat (4 * mMul + 2) @(posedge clk);
    rc(BWC);
    xtalRun <= 1'b1;
    wr(BWC, 8'h20);
    @(posedge clk);
    chk({7'h00, trackingModeOut}, 8'h01);
    cnt_base(16, 2);
    wr(BWC, 8'hA0);
    loopTrackingIn <= 1'($urandom());
    repeat (2) @(posedge clk);
    rc(BWC);
    wr(BWC, 8'h00);
    rc(BWC);
    wr(BWC, 8'h80);
    wr(CTL, 8'hA0);
    // two plain lock changes, then break with clearing barred and allowed
    for (int j = 0; j < 4; j++) begin
      if (j == 2) breakStateIn <= 1'b1;
      if (j == 3) breakClearEnableIn <= 1'b1;
      loopLockedIn <= ~loopLockedIn;
      mFlag = 1'b1;
      repeat (4) @(posedge clk);
      chk({7'h00, loopInterruptOut}, 8'h01);
      rc(CTL);
      rc(CTL);
      chk({7'h00, loopInterruptOut}, {7'h00, mFlag});
      rc(BWC);
    end
    breakStateIn <= 1'b0;
    rc(CTL);
    wr(CTL, 8'h20);
    loopLockedIn <= ~loopLockedIn;
    mFlag = 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, loopInterruptOut}, 8'h00);
    rc(CTL);
    wr(BWC, 8'h00);
    loopLockedIn <= ~loopLockedIn;
    repeat (4) @(posedge clk);
    rc(CTL);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule

bind pbc_loop_ctrl pbc_loop_ctrl_props #(.ADDR_W(ADDR_W)) pbc_loop_ctrl_props_i (
  .clk               (clk),
  .rst               (rst),
  .addr              (addr),
  .wrEn              (wrEn),
  .rdEn              (rdEn),
  .rdData            (rdData),
  .loopTrackingIn    (loopTrackingIn),
  .oscillatorEnableIn(oscillatorEnableIn),
  .crystalClockOut   (crystalClockOut),
  .baseClockOut      (baseClockOut),
  .loopInterruptOut  (loopInterruptOut),
  .loopPowerOnOut    (loopPowerOnOut),
  .trackingModeOut   (trackingModeOut),
  .autoModeOut       (autoModeOut),
  .loopFactorNOut    (loopFactorNOut),
  .vcoRangeOut       (vcoRangeOut)
);
